// File: hdl/stom_pkg.sv
// Constants and carriers for the safe torque cut-off monitor.
// Assumes a 100 MHz control clock; all times are converted here.
package stom_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ = 100000000;
	localparam int PULSE_IGNORE_US = 1000;
	// An off pulse must outlast this many cycles to count as off
	localparam int FILT_CYCLES = PULSE_IGNORE_US * (CLK_HZ / 1000000);
	localparam int CUT_LIMIT_US = 5000;
	localparam int CUT_LIMIT_CYCLES = CUT_LIMIT_US * (CLK_HZ / 1000000);
	localparam int MON_LIMIT_US = 6000;
	localparam int MON_LIMIT_CYCLES = MON_LIMIT_US * (CLK_HZ / 1000000);
	localparam int CNT_W = 18;

	// ==========================================================
	// Reset values
	localparam logic [1:0] SYNC_RESET = 2'h3;
	localparam logic [CNT_W-1:0] CNT_RESET = 18'h00000;

	// ==========================================================
	// Stop behaviour selection
	typedef enum logic [1:0]
	{
		STOM_STOP_DYN_BRAKE = 2'b00,
		STOM_STOP_FREE_RUN = 2'b01,
		STOM_STOP_DYN_THEN_FREE = 2'b10,
		STOM_STOP_FREE_THEN_DYN = 2'b11
	} stom_stop_t;

	// ==========================================================
	// Cut-off state machine
	typedef enum logic [1:0]
	{
		STOM_RUN = 2'b00,
		STOM_CUT = 2'b01,
		STOM_ALARM = 2'b10
	} stom_state_t;

	// Gate drive carrier: one bit per arm, high means drive allowed
	typedef struct packed
	{
		logic upperEn;
		logic lowerEn;
	} stom_gate_t;

endpackage

// File: hdl/stom_top.sv
// Safe torque cut-off monitor: filters two safety inputs, blocks gates,
// drops ready, selects stop behaviour and drives the monitor output.
// Assumes the safety inputs are high for on; off requests cut torque.
`timescale 1ns/1ns

// ==========================================================
// Per-input qualifier: synchronizer then off-pulse filter
module stom_filter
(
	input wire logic core_clk,
	input wire logic rstSync_n,
	input wire logic rawIn,
	output logic onOut
);
	logic [1:0] sync_reg;
	logic [stom_pkg::CNT_W-1:0] cnt_reg;
	logic on_reg;

	// ==========================================================
	// Synchronizer
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			sync_reg <= stom_pkg::SYNC_RESET;
		else
			sync_reg <= {sync_reg[0], rawIn};
	end

	// ==========================================================
	// Off qualification: self-test low pulses never reach the counter limit
	// Counter stops at the limit, so its width only needs to hold FILT_CYCLES
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			cnt_reg <= stom_pkg::CNT_RESET;
			on_reg <= 1'b0;
		end
		else if (sync_reg[1])
		begin
			cnt_reg <= stom_pkg::CNT_RESET;
			on_reg <= 1'b1;
		end
		else if (cnt_reg >= stom_pkg::CNT_W'(stom_pkg::FILT_CYCLES))
			on_reg <= 1'b0;
		else
			cnt_reg <= cnt_reg + 18'h00001;
	end

	assign onOut = on_reg;
endmodule

// ==========================================================
// Top: cut-off state, gate blocking, ready, brake and monitor
module stom_top
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic safety_in_upper,
	input wire logic safety_in_lower,
	input wire logic alarmClear,
	input wire stom_pkg::stom_stop_t alarm_stop_select,
	input wire stom_pkg::stom_gate_t gateReq,
	output stom_pkg::stom_gate_t gateOut,
	output logic servoReady,
	output logic ext_monitor_out,
	output logic safe_torque_cut,
	output logic alarmActive,
	output logic dynBrakeOn
);
	// ==========================================================
	// Internal state
	logic [1:0] rst_reg;
	logic rstSync_n;
	logic upperOn;
	logic lowerOn;
	logic anyOff;
	stom_pkg::stom_state_t state_reg;
	logic upperGate_reg;
	logic lowerGate_reg;
	logic runOk;
	logic ready_reg;
	logic mon_reg;
	logic brake_reg;

	// ==========================================================
	// Reset release
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rst_reg <= 2'h0;
		else
			rst_reg <= {rst_reg[0], 1'b1};
	end
	assign rstSync_n = rst_reg[1];

	// ==========================================================
	// Input qualification
	stom_filter upperFilt
	(
		.core_clk(core_clk),
		.rstSync_n(rstSync_n),
		.rawIn(safety_in_upper),
		.onOut(upperOn)
	);
	stom_filter lowerFilt
	(
		.core_clk(core_clk),
		.rstSync_n(rstSync_n),
		.rawIn(safety_in_lower),
		.onOut(lowerOn)
	);
	assign anyOff = !upperOn || !lowerOn;

	// ==========================================================
	// Cut-off state: latches until cleared with both inputs on
	// Power-up lands in cut, so a clear with both inputs on is needed first
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			state_reg <= stom_pkg::STOM_CUT;
		else
		begin
			unique case (state_reg)
				stom_pkg::STOM_RUN:
					if (anyOff)
						state_reg <= stom_pkg::STOM_CUT;
				stom_pkg::STOM_CUT:
					if (alarmClear && !anyOff)
						state_reg <= stom_pkg::STOM_RUN;
					else if (alarmClear)
						state_reg <= stom_pkg::STOM_ALARM;
				// Stays here until a clear finds both inputs on
				stom_pkg::STOM_ALARM:
					if (alarmClear && !anyOff)
						state_reg <= stom_pkg::STOM_RUN;
				default:
					state_reg <= stom_pkg::STOM_CUT;
			endcase
		end
	end

	// ==========================================================
	// Gate blocking acts on each arm directly, not only via the state
	// Both arms drop on the same edge the state machine sees the off input
	assign runOk = (state_reg == stom_pkg::STOM_RUN) && !anyOff;

	// ==========================================================
	// Upper arm
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			upperGate_reg <= 1'b0;
		else
			upperGate_reg <= gateReq.upperEn && upperOn && runOk;
	end

	// ==========================================================
	// Lower arm
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			lowerGate_reg <= 1'b0;
		else
			lowerGate_reg <= gateReq.lowerEn && lowerOn && runOk;
	end

	// ==========================================================
	// Ready output
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			ready_reg <= 1'b0;
		else
			ready_reg <= runOk;
	end

	// ==========================================================
	// Stop behaviour: brake engaged for the braking selections while cut
	// Free run leaves the brake off, so the stopping distance grows
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			brake_reg <= 1'b0;
		else
			brake_reg <= ((state_reg != stom_pkg::STOM_RUN) || anyOff) &&
				(alarm_stop_select != stom_pkg::STOM_STOP_FREE_RUN);
	end

	// ==========================================================
	// Monitor output: not a safety path, diagnostics only
	always_ff @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			mon_reg <= 1'b0;
		else
			mon_reg <= !upperOn && !lowerOn;
	end

	// ==========================================================
	// Outputs
	assign gateOut = '{upperEn: upperGate_reg, lowerEn: lowerGate_reg};
	assign servoReady = ready_reg;
	assign ext_monitor_out = mon_reg;
	assign safe_torque_cut = (state_reg != stom_pkg::STOM_RUN);
	assign alarmActive = (state_reg == stom_pkg::STOM_ALARM);
	assign dynBrakeOn = brake_reg;
endmodule

// File: testbench/stom_top_asserts.sv
// Port checker for the cut-off monitor top.
// Assumes 100 MHz core_clk and the bind below.
`timescale 1ns/1ns
module stom_chk
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic safety_in_upper,
	input wire logic safety_in_lower,
	input wire logic alarmClear,
	input wire stom_pkg::stom_stop_t alarm_stop_select,
	input wire stom_pkg::stom_gate_t gateReq,
	input wire stom_pkg::stom_gate_t gateOut,
	input wire logic servoReady,
	input wire logic ext_monitor_out,
	input wire logic safe_torque_cut,
	input wire logic alarmActive,
	input wire logic dynBrakeOn
);
	// ==========================================================
	// Off-time counters, saturating
	localparam int LIM = stom_pkg::FILT_CYCLES + 10;
	logic [17:0] upReg;
	logic [17:0] bothReg;
	logic bothOn;
	assign bothOn = safety_in_upper & safety_in_lower;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn) upReg <= '0;
		else if (safety_in_upper) upReg <= '0;
		else if (upReg != '1) upReg <= upReg + 18'h00001;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn) bothReg <= '0;
		else if (safety_in_upper || safety_in_lower) bothReg <= '0;
		else if (bothReg != '1) bothReg <= bothReg + 18'h00001;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_cut; int'(upReg) == LIM |-> safe_torque_cut; endproperty
	a_cut: assert property (p_cut) else $error("cut late");
	property p_up; $rose(safe_torque_cut) |-> ##[1:2] !gateOut.upperEn; endproperty
	a_up: assert property (p_up) else $error("upper gate on");
	property p_lo; $rose(safe_torque_cut) |-> ##[1:2] !gateOut.lowerEn; endproperty
	a_lo: assert property (p_lo) else $error("lower gate on");
	property p_rdy; safe_torque_cut [*3] |-> !servoReady; endproperty
	a_rdy: assert property (p_rdy) else $error("ready while cut");
	property p_mon; ext_monitor_out |-> !$past(bothOn, 8); endproperty
	a_mon: assert property (p_mon) else $error("monitor on wrongly");
	property p_mtime; int'(bothReg) == LIM |-> ext_monitor_out; endproperty
	a_mtime: assert property (p_mtime) else $error("monitor late");
	property p_alm; $rose(alarmActive) |-> $past(alarmClear); endproperty
	a_alm: assert property (p_alm) else $error("alarm no clear");
	property p_exit; $fell(safe_torque_cut) |-> $past(alarmClear); endproperty
	a_exit: assert property (p_exit) else $error("left cut alone");
	property p_brk; dynBrakeOn |-> $past(alarm_stop_select) != stom_pkg::STOM_STOP_FREE_RUN;
	endproperty
	a_brk: assert property (p_brk) else $error("brake in free run");
	c_cut: cover property ($rose(safe_torque_cut));
	c_mon: cover property ($rose(ext_monitor_out));
	c_alm: cover property ($rose(alarmActive));
endmodule
bind stom_top stom_chk stom_chk_inst (.*);

// File: testbench/stom_safety_ctrl.sv
// Model of the outside safety controller.
// Assumes the monitor follows within its deadline.
`timescale 1ns/1ns
module stom_safety_ctrl
(
	input wire logic core_clk,
	input wire logic reqUp,
	input wire logic reqLo,
	input wire logic monIn,
	output logic sfUp,
	output logic sfLo,
	output logic fault
);
	logic [19:0] missReg;
	// Low level asks for the cut, so a broken wire stops the motor
	assign sfUp = !reqUp;
	assign sfLo = !reqLo;
	always @(posedge core_clk)
		if (monIn === (reqUp & reqLo)) missReg <= '0;
		else missReg <= missReg + 20'h00001;
	assign fault = missReg > stom_pkg::MON_LIMIT_CYCLES;
endmodule

// File: testbench/tb.sv
// Self-checking bench for the cut-off monitor.
// Assumes the controller model drives the safety inputs.
`timescale 1ns/1ns
module tb;
	logic core_clk = 0;
	logic rstn = 0;
	logic reqUp = 0;
	logic reqLo = 0;
	logic alarmClear = 0;
	logic sfUp, sfLo, fault, mon, cut, alm, rdy, brk;
	logic [7:0] st;
	stom_pkg::stom_gate_t gateOut;
	stom_pkg::stom_stop_t sel = stom_pkg::STOM_STOP_DYN_BRAKE;
	stom_pkg::stom_gate_t greq = 2'h3;
	int n_fail = 0;
	int n_compared = 0;
	always #5 core_clk = ~core_clk;
	assign st = {1'b0, gateOut, rdy, mon, cut, alm, brk};
	stom_safety_ctrl stom_safety_ctrl_inst (.core_clk(core_clk), .reqUp(reqUp), .reqLo(reqLo),
		.monIn(mon), .sfUp(sfUp), .sfLo(sfLo), .fault(fault));
	stom_top stom_top_inst (.core_clk(core_clk), .rstn(rstn), .safety_in_upper(sfUp),
		.safety_in_lower(sfLo), .alarmClear(alarmClear),
		.alarm_stop_select(sel), .gateReq(greq), .gateOut(gateOut),
		.servoReady(rdy), .ext_monitor_out(mon), .safe_torque_cut(cut), .alarmActive(alm),
		.dynBrakeOn(brk));
	task wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task check(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task clr;
		alarmClear <= 1;
		wt(1);
		alarmClear <= 0;
		wt(4);
	endtask
	task t_run;
		wt(10);
		clr;
		check(st, 8'h70);
		check({7'h0, fault}, 8'h00);
	endtask
	task t_pulse;
		reqUp <= 1;
		wt(stom_pkg::FILT_CYCLES);
		reqUp <= 0;
		wt(10);
		check(st, 8'h70);
	endtask
	// Held well past the filter so the request is never ambiguous
	task t_cut;
		reqUp <= 1;
		reqLo <= 1;
		wt(500100);
		check(st, 8'h0D);
		check({7'h0, fault}, 8'h00);
	endtask
	task t_alarm;
		reqUp <= 0;
		wt(10);
		clr;
		check(st, 8'h07);
		sel <= stom_pkg::STOM_STOP_FREE_RUN;
		wt(2);
		check(st, 8'h06);
		sel <= stom_pkg::STOM_STOP_DYN_BRAKE;
	endtask
	task t_gate;
		greq <= 2'h2;
		wt(3);
		check(st, 8'h50);
		greq <= 2'h1;
		wt(3);
		check(st, 8'h30);
		greq <= 2'h3;
	endtask
	initial
	begin
		wt(4);
		rstn <= 1;
		t_run;
		t_pulse;
		t_cut;
		t_alarm;
		reqLo <= 0;
		t_run;
		t_gate;
		close_out;
	end
	initial
	begin
		wt(700000);
		n_fail++;
		close_out;
	end
endmodule
